// ==== src/gpio_led_pkg.sv ====
package gpio_led_pkg;
  // pin count and clock rate
  localparam int PIN_COUNT = 3;
  localparam int CLK_MHZ = 100;
  // blink phase length in milliseconds
  localparam int BLINK_MS = 80;
  localparam int BLINK_CYCLES = BLINK_MS * CLK_MHZ * 1000;
  // pin index of each led function
  localparam int SPEED_PIN = 0;
  localparam int LINK_PIN = 1;
  localparam int DUPLEX_PIN = 2;
  // pin direction modes
  typedef enum logic [1:0] {
    MODE_INPUT      = 2'h0,
    MODE_PUSH_PULL  = 2'h1,
    MODE_OPEN_DRAIN = 2'h2
  } pin_mode_type;
  // per-pin software configuration
  typedef struct packed {
    logic         led_sel;
    pin_mode_type mode;
    logic         out_val;
  } pin_cfg_type;
  // status from the phy
  typedef struct packed {
    logic speed_100;
    logic autoneg_busy;
    logic link_up;
    logic activity;
    logic full_duplex;
  } phy_status_type;
  // activity blinker states
  typedef enum logic [1:0] {
    BLINK_IDLE = 2'h0,
    BLINK_OFF  = 2'h1,
    BLINK_ON   = 2'h2
  } blink_state_type;
endpackage

// ==== src/activity_blinker.sv ====
`timescale 1ns/1ps
module activity_blinker #(
  parameter int PHASE_CYCLES = gpio_led_pkg::BLINK_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_link_up,
  input  wire logic i_activity,
  output logic      o_led_n
);
  initial begin
    if (PHASE_CYCLES < 2) $error("phase too short");
  end
  localparam int CW = $clog2(PHASE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PHASE_CYCLES - 1);
  gpio_led_pkg::blink_state_type state;
  gpio_led_pkg::blink_state_type next_state;
  logic [CW-1:0] count;
  logic          count_done;
  logic          next_led_n;
  assign count_done = (count == LAST);
  // next state: off pulse, then on guard, then repeat on activity
  always_comb begin
    next_state = state;
    unique case (state)
      gpio_led_pkg::BLINK_IDLE: if (i_activity) next_state = gpio_led_pkg::BLINK_OFF;
      gpio_led_pkg::BLINK_OFF:  if (count_done) next_state = gpio_led_pkg::BLINK_ON;
      gpio_led_pkg::BLINK_ON: begin
        if (count_done) next_state = i_activity ? gpio_led_pkg::BLINK_OFF : gpio_led_pkg::BLINK_IDLE;
      end
      default: next_state = gpio_led_pkg::BLINK_IDLE;
    endcase
  end
  // off while the pulse runs or the link is down; lit solid otherwise
  assign next_led_n = i_link_up ? (next_state == gpio_led_pkg::BLINK_OFF) : 1'b1;
  // state and phase counter
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state   <= gpio_led_pkg::BLINK_IDLE;
      count   <= '0;
      o_led_n <= 1'b1;
    end else begin
      state   <= next_state;
      count   <= (next_state != state) ? '0 : (count_done ? count : count + 1'b1);
      o_led_n <= next_led_n;
    end
  end
  // off pulse holds for at least two cycles, count reaching 1
  sequence seq_off_start;
    $rose(state == gpio_led_pkg::BLINK_OFF);
  endsequence
  AST_OFF_LEN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    seq_off_start |-> (state == gpio_led_pkg::BLINK_OFF) [*2] ##0 (count == CW'(1)))
    else $error("off pulse ended early");
  AST_ON_GUARD: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(state == gpio_led_pkg::BLINK_OFF) |-> state == gpio_led_pkg::BLINK_ON && count == '0)
    else $error("no on guard after off pulse");
  AST_START: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state == gpio_led_pkg::BLINK_IDLE && i_activity) |=> state == gpio_led_pkg::BLINK_OFF)
    else $error("activity did not start blink");
endmodule // activity_blinker

// ==== src/gpio_led_indicator.sv ====
`timescale 1ns/1ps
module gpio_led_indicator #(
  parameter int PINS         = gpio_led_pkg::PIN_COUNT,
  parameter int PHASE_CYCLES = gpio_led_pkg::BLINK_CYCLES
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire gpio_led_pkg::pin_cfg_type   i_cfg [PINS],
  input  wire gpio_led_pkg::phy_status_type i_phy,
  input  wire logic [PINS-1:0]             i_pin,
  output logic [PINS-1:0]                  o_pin,
  output logic [PINS-1:0]                  o_pin_oe,
  output logic [PINS-1:0]                  o_pin_in
);
  initial begin
    if (PINS != gpio_led_pkg::PIN_COUNT) $error("pin count fixed at three");
  end
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic            speed_led_n;
  logic            link_activity_led_n;
  logic            duplex_led_n;
  logic            speed_10;
  logic [PINS-1:0] led_val;
  logic [PINS-1:0] next_out;
  logic [PINS-1:0] next_oe;
  // 10M speed indication
  assign speed_10 = i_phy.link_up && !i_phy.speed_100 && !i_phy.autoneg_busy;
  // link led blinker
  activity_blinker #(
    .PHASE_CYCLES (PHASE_CYCLES)
  ) u_blink (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_link_up  (i_phy.link_up),
    .i_activity (i_phy.activity),
    .o_led_n    (link_activity_led_n)
  );
  // registered led levels
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      speed_led_n  <= 1'b0;
      duplex_led_n <= 1'b1;
    end else begin
      speed_led_n  <= speed_10;
      duplex_led_n <= !(i_phy.link_up && i_phy.full_duplex);
    end
  end
  assign led_val[gpio_led_pkg::SPEED_PIN]  = speed_led_n;
  assign led_val[gpio_led_pkg::LINK_PIN]   = link_activity_led_n;
  assign led_val[gpio_led_pkg::DUPLEX_PIN] = duplex_led_n;
  // pin drive selection
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (i_cfg[i].led_sel) begin
        next_out[i] = 1'b0;
        next_oe[i]  = !led_val[i];
      end else begin
        unique case (i_cfg[i].mode)
          gpio_led_pkg::MODE_PUSH_PULL: begin
            next_out[i] = i_cfg[i].out_val;
            next_oe[i]  = 1'b1;
          end
          gpio_led_pkg::MODE_OPEN_DRAIN: begin
            next_out[i] = 1'b0;
            next_oe[i]  = !i_cfg[i].out_val;
          end
          default: begin
            next_out[i] = 1'b0;
            next_oe[i]  = 1'b0;
          end
        endcase
      end
    end
  end
  // output and input synchroniser registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin    <= '0;
      o_pin_oe <= '0;
      sync1    <= '0;
      sync2    <= '0;
    end else begin
      o_pin    <= next_out;
      o_pin_oe <= next_oe;
      sync1    <= i_pin;
      sync2    <= sync1;
    end
  end
  assign o_pin_in = sync2;
  // checks
  AST_LED_NEVER_HIGH: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cfg[0].led_sel |=> !o_pin[0])
    else $error("led pin driven high");
  AST_SPEED_10: assert property (@(posedge i_clk) disable iff (!i_nrst)
    speed_10 |=> speed_led_n)
    else $error("speed led not off at 10M");
  AST_SPEED_100: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_phy.speed_100 || !i_phy.link_up) |=> !speed_led_n)
    else $error("speed led not lit");
  AST_DUPLEX: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_phy.link_up && i_phy.full_duplex) |=> !duplex_led_n)
    else $error("duplex led not lit");
  AST_PP: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[1].led_sel && i_cfg[1].mode == gpio_led_pkg::MODE_PUSH_PULL) |=> o_pin_oe[1])
    else $error("push-pull not driven");
  AST_INPUT: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[2].led_sel && i_cfg[2].mode == gpio_led_pkg::MODE_INPUT) |=> !o_pin_oe[2])
    else $error("input pin driven");
  AST_LED_OD: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg[1].led_sel && i_cfg[1].mode == gpio_led_pkg::MODE_PUSH_PULL) |=> !o_pin[1])
    else $error("led pin push-pull");

  // led pins drive low or release, never high
  AST_LED_OD0: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cfg[0].led_sel |=> !o_pin[0])
    else $error("led pin 0 driven high");
  AST_LED_OD1: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cfg[1].led_sel |=> !o_pin[1])
    else $error("led pin 1 driven high");
  AST_LED_OD2: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cfg[2].led_sel |=> !o_pin[2])
    else $error("led pin 2 driven high");

  // led pins show the selected status one cycle later
  AST_LED_FOLLOW0: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cfg[0].led_sel |=> o_pin_oe[0] == !$past(led_val[0]))
    else $error("speed led not on pin");
  AST_LED_FOLLOW1: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cfg[1].led_sel |=> o_pin_oe[1] == !$past(led_val[1]))
    else $error("link led not on pin");
  AST_LED_FOLLOW2: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cfg[2].led_sel |=> o_pin_oe[2] == !$past(led_val[2]))
    else $error("duplex led not on pin");

  // open-drain pins drive low or release by out_val
  AST_OD_MODE0: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[0].led_sel && i_cfg[0].mode == gpio_led_pkg::MODE_OPEN_DRAIN) |=> (!o_pin[0] && o_pin_oe[0] == !$past(i_cfg[0].out_val)))
    else $error("open-drain pin 0 wrong");
  AST_OD_MODE1: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[1].led_sel && i_cfg[1].mode == gpio_led_pkg::MODE_OPEN_DRAIN) |=> (!o_pin[1] && o_pin_oe[1] == !$past(i_cfg[1].out_val)))
    else $error("open-drain pin 1 wrong");
  AST_OD_MODE2: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[2].led_sel && i_cfg[2].mode == gpio_led_pkg::MODE_OPEN_DRAIN) |=> (!o_pin[2] && o_pin_oe[2] == !$past(i_cfg[2].out_val)))
    else $error("open-drain pin 2 wrong");

  // push-pull pins drive out_val
  AST_PP_VAL0: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[0].led_sel && i_cfg[0].mode == gpio_led_pkg::MODE_PUSH_PULL) |=> o_pin[0] == $past(i_cfg[0].out_val))
    else $error("push-pull pin 0 value wrong");
  AST_PP_VAL1: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[1].led_sel && i_cfg[1].mode == gpio_led_pkg::MODE_PUSH_PULL) |=> o_pin[1] == $past(i_cfg[1].out_val))
    else $error("push-pull pin 1 value wrong");
  AST_PP_VAL2: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[2].led_sel && i_cfg[2].mode == gpio_led_pkg::MODE_PUSH_PULL) |=> o_pin[2] == $past(i_cfg[2].out_val))
    else $error("push-pull pin 2 value wrong");

  // input pins, and the unused mode code, stay released
  AST_IN_MODE0: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[0].led_sel && i_cfg[0].mode != gpio_led_pkg::MODE_PUSH_PULL && i_cfg[0].mode != gpio_led_pkg::MODE_OPEN_DRAIN) |=> !o_pin_oe[0])
    else $error("input pin 0 driven");
  AST_IN_MODE1: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[1].led_sel && i_cfg[1].mode != gpio_led_pkg::MODE_PUSH_PULL && i_cfg[1].mode != gpio_led_pkg::MODE_OPEN_DRAIN) |=> !o_pin_oe[1])
    else $error("input pin 1 driven");
  AST_IN_MODE2: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_cfg[2].led_sel && i_cfg[2].mode != gpio_led_pkg::MODE_PUSH_PULL && i_cfg[2].mode != gpio_led_pkg::MODE_OPEN_DRAIN) |=> !o_pin_oe[2])
    else $error("input pin 2 driven");

  // a released pin always carries a low drive value
  AST_REL_LOW0: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_pin_oe[0] |-> !o_pin[0])
    else $error("released pin 0 not low");
  AST_REL_LOW1: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_pin_oe[1] |-> !o_pin[1])
    else $error("released pin 1 not low");
  AST_REL_LOW2: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_pin_oe[2] |-> !o_pin[2])
    else $error("released pin 2 not low");

  // speed led lit during auto-negotiation
  AST_SPEED_AUTONEG: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_phy.autoneg_busy |=> !speed_led_n)
    else $error("speed led off in auto-negotiation");

  // duplex led off without a full-duplex link
  AST_DUPLEX_OFF: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(i_phy.link_up && i_phy.full_duplex) |=> duplex_led_n)
    else $error("duplex led lit in half duplex");

  // led levels reach the pins one cycle after the led register
  AST_SPEED_PIN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (speed_10 ##1 i_cfg[0].led_sel) |=> !o_pin_oe[0])
    else $error("speed pin not released at 10M");
  AST_DUPLEX_PIN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ((i_phy.link_up && i_phy.full_duplex) ##1 i_cfg[2].led_sel) |=> (o_pin_oe[2] && !o_pin[2]))
    else $error("duplex pin not pulled low");

  // pin level reaches the input port two cycles later
  AST_PIN_SYNC: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $past(i_nrst, 2) |-> o_pin_in == $past(i_pin, 2))
    else $error("input sync latency wrong");

  // link led released with no link
  sequence seq_no_link;
    !i_phy.link_up;
  endsequence
  sequence seq_link_released;
    link_activity_led_n;
  endsequence
  AST_NO_LINK_OFF: assert property (@(posedge i_clk) disable iff (!i_nrst)
    seq_no_link |=> seq_link_released)
    else $error("link led lit without link");
endmodule // gpio_led_indicator

// ==== sim/board_model.sv ====
`timescale 1ns/1ps
module board_model (
  input  wire logic [2:0] i_pin_drv,
  input  wire logic [2:0] i_pin_oe,
  input  wire logic       i_ext_en,
  input  wire logic [2:0] i_ext_val,
  output logic      [2:0] o_level
);
  // pull-up wins on a released pad while i_ext_en is low; i_ext_en forces i_ext_val on every pad
  assign o_level = i_ext_en ? i_ext_val : (i_pin_oe & i_pin_drv) | ~i_pin_oe;
endmodule // board_model

// ==== sim/gpio_led_indicator_test.sv ====
`timescale 1ns/1ps
module gpio_led_indicator_test;
  logic                         clk = 1'b0;
  logic                         nrst = 1'b0;
  logic                         ext_en = 1'b0;
  logic [2:0]                   ext_val = 3'h0;
  gpio_led_pkg::pin_cfg_type    cfg [3];
  gpio_led_pkg::phy_status_type phy = '0;
  logic [2:0]                   pin_o, pin_oe, pin_in, level;
  int                           fails = 0, cmp_count = 0, n;
  // speed and duplex lit per case
  localparam logic [4:0] CASES [5] = '{5'h15, 5'h0D, 5'h01, 5'h04, 5'h05};
  localparam logic [4:0] SPD_LIT = 5'h07;
  localparam logic [4:0] DUP_LIT = 5'h13;
  always #5 clk = ~clk;
  gpio_led_indicator #(.PHASE_CYCLES(8)) uut (.i_clk(clk), .i_nrst(nrst), .i_cfg(cfg), .i_phy(phy),
    .i_pin(level), .o_pin(pin_o), .o_pin_oe(pin_oe), .o_pin_in(pin_in));
  board_model board (.i_pin_drv(pin_o), .i_pin_oe(pin_oe), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_level(level));
  // comparison and helpers
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task pad(input string what, input int k, input logic lit);
    chk(what, lit ? 8'h02 : 8'h01, {6'h0, pin_oe[k], level[k]});
  endtask
  task set_cfg(input logic sel, input logic [1:0] m, input logic [2:0] v);
    for (int k = 0; k < 3; k++) begin
      cfg[k] = '{sel, gpio_led_pkg::pin_mode_type'(m), v[k]};
    end
  endtask
  task settle;
    repeat (3) @(negedge clk);
  endtask
  task run_len(input logic oe, output int len);
    len = 0;
    while (pin_oe[1] === oe && len < 40) begin
      len++;
      @(negedge clk);
    end
  endtask
  // plain pin modes
  task t_gpio;
    set_cfg(1'b0, 2'h1, 3'h5);
    settle;
    chk("pp_hi", 8'h03, {6'h0, pin_oe[0], level[0]});
    pad("pp_lo", 1, 1'b1);
    set_cfg(1'b0, 2'h2, 3'h5);
    settle;
    pad("od_hi", 0, 1'b0);
    pad("od_lo", 1, 1'b1);
    set_cfg(1'b0, 2'h0, 3'h7);
    ext_en = 1'b1;
    ext_val = 3'h2;
    settle;
    chk("in", 8'h02, {5'h0, pin_oe | pin_in});
    ext_en = 1'b0;
  endtask
  // speed and duplex leds over push-pull setting
  task t_leds;
    set_cfg(1'b1, 2'h1, 3'h7);
    for (int i = 0; i < 5; i++) begin
      phy = gpio_led_pkg::phy_status_type'(CASES[i]);
      settle;
      pad("speed", 0, SPD_LIT[i]);
      pad("duplex", 2, DUP_LIT[i]);
    end
  endtask
  // link led blink timing
  task t_link;
    phy = gpio_led_pkg::phy_status_type'(5'h04);
    settle;
    pad("link", 1, 1'b1);
    phy.activity = 1'b1;
    @(negedge clk);
    phy.activity = 1'b0;
    run_len(1'b1, n);
    run_len(1'b0, n);
    chk("off", 8'h08, n[7:0]);
    run_len(1'b1, n);
    chk("solid", 8'h28, n[7:0]);
    phy.activity = 1'b1;
    run_len(1'b1, n);
    run_len(1'b0, n);
    chk("off2", 8'h08, n[7:0]);
    run_len(1'b1, n);
    chk("gap", 8'h01, {7'h0, n >= 8 && n <= 10});
    run_len(1'b0, n);
    chk("off3", 8'h08, n[7:0]);
  endtask
  task print_verdict;
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    set_cfg(1'b0, 2'h0, 3'h0);
    repeat (3) @(negedge clk);
    chk("rst_oe", 8'h00, {5'h0, pin_oe});
    nrst = 1'b1;
    t_gpio;
    t_leds;
    t_link;
    print_verdict;
  end
  // watchdog
  initial begin
    #20000;
    fails++;
    print_verdict;
  end
endmodule // gpio_led_indicator_test
